// ===== uart_char_params.svh
`ifndef UART_CHAR_PARAMS_SVH
`define UART_CHAR_PARAMS_SVH

// register offsets on the host bus
`define REG_DATA 3'h0
`define REG_IRQ_MASK 3'h1
`define REG_IDENT_FIFO 3'h2
`define REG_ENH_FEATURE 3'h3
`define REG_OVERSAMPLE 3'h4
`define REG_LINE_STATUS 3'h5
`define REG_MODEM 3'h6

// irq_mask_reg fields
`define IER_RX_AVAIL 0
`define IER_TX_ROOM 1
`define IER_LINE_STAT 2
`define IER_MODEM 3
`define IER_SLEEP 4
`define IER_XOFF 5
`define IER_RTS 6
`define IER_CTS 7

// other fields
`define EFR_ENHANCED 4
`define FCR_ENABLE 0
`define FCR_RX_FLUSH 1
`define FCR_TX_FLUSH 2
`define MCR_RTS 1

// reset values
`define IRQ_MASK_RST 8'h00
`define FCR_TRIG_RST 2'h0
`define OVERSAMPLE_RST 2'h0

// interrupt identification codes
`define ISR_NONE 8'h01
`define ISR_LINE 8'h06
`define ISR_RX 8'h04
`define ISR_TX 8'h02
`define ISR_MODEM 8'h00
`define ISR_XOFF 8'h10
`define ISR_FLOW 8'h20

// receive trigger levels
`define TRIG_0 8
`define TRIG_1 16
`define TRIG_2 24
`define TRIG_3 28

`endif

// ===== uart_char_pkg.sv
package uart_char_pkg;

  typedef enum logic [1:0] {RX_IDLE, RX_START, RX_DATA, RX_STOP} rx_state_t;
  typedef enum logic {TX_IDLE, TX_SHIFT} tx_state_t;

  typedef struct packed {
    logic brk;
    logic framing;
    logic parity;
    logic overrun;
  } rx_err_t;

  typedef struct packed {
    logic cd;
    logic ri;
    logic dsr;
    logic cts;
  } modem_t;

endpackage

// ===== uart_char_path.sv
`include "uart_char_params.svh"
`timescale 1ns/1ps
`default_nettype none

module uart_char_path import uart_char_pkg::*; #(
  parameter int DEPTH = 128,
  parameter int SAMPLE_DIV = 1,
  parameter logic [7:0] XOFF_CHAR = 8'h13
) (
  input wire logic CLK_IN,
  input wire logic RST_B_IN,
  input wire logic [2:0] ADDR_IN,
  input wire logic [7:0] DATA_IN,
  input wire logic WR_IN,
  input wire logic RD_IN,
  input wire logic RX_IN,
  input wire logic CTS_IN,
  input wire logic DSR_IN,
  input wire logic RI_IN,
  input wire logic CD_IN,
  output logic [7:0] DATA_OUT,
  output logic IRQ_OUT,
  output logic TX_OUT,
  output logic RTS_OUT,
  output logic SLEEP_OUT
);

  localparam int CW = $clog2(DEPTH + 1);
  localparam int PW = $clog2(DEPTH);
  localparam int DW = $clog2(SAMPLE_DIV + 1);

  logic [7:0] irq_mask_reg;
  logic fifo_en;
  logic [1:0] rx_trig_sel;
  logic enh_en;
  logic [1:0] oversample_select;
  logic [7:0] tx_mem [DEPTH];
  logic [7:0] rx_mem [DEPTH];
  logic [PW-1:0] tx_wp, tx_rp, rx_wp, rx_rp;
  logic [CW-1:0] tx_count, rx_count, cap, trig;
  rx_err_t line_err;
  modem_t modem_prev, modem_delta;
  logic cts_flag, rts_flag, xoff_flag, tx_empty_flag;
  logic [DW-1:0] div_cnt;
  logic tick;
  logic [4:0] ratio;
  rx_state_t rx_state;
  tx_state_t tx_state;
  logic [4:0] rx_tick_cnt, tx_tick_cnt;
  logic [3:0] rx_bit_cnt, tx_bit_cnt;
  logic [7:0] rx_shift_reg;
  logic [9:0] tx_shift_reg;
  logic rx_prev;
  logic [7:0] irq_ident_reg;
  logic ls_src, rx_src, tx_src, ms_src, xoff_src, rts_src, cts_src;

  wire wr_data = WR_IN && ADDR_IN == `REG_DATA;
  wire rd_data = RD_IN && ADDR_IN == `REG_DATA;
  wire wr_fcr = WR_IN && ADDR_IN == `REG_IDENT_FIFO;
  wire rd_isr = RD_IN && ADDR_IN == `REG_IDENT_FIFO;
  wire rd_lsr = RD_IN && ADDR_IN == `REG_LINE_STATUS;
  wire rd_msr = RD_IN && ADDR_IN == `REG_MODEM;
  wire fifo_change = wr_fcr && DATA_IN[`FCR_ENABLE] != fifo_en;
  wire tx_flush = wr_fcr && (DATA_IN[`FCR_TX_FLUSH] || fifo_change);
  wire rx_flush = wr_fcr && (DATA_IN[`FCR_RX_FLUSH] || fifo_change);
  wire tx_push = wr_data && tx_count < cap;
  wire tx_pop = tx_state == TX_IDLE && tx_count != '0;
  wire rx_pop = rd_data && rx_count != '0;
  wire frame_end = rx_state == RX_STOP && tick && rx_tick_cnt == ratio - 5'd1;
  wire rx_push = frame_end && RX_IN && rx_count < cap;
  wire rx_overrun = frame_end && RX_IN && rx_count >= cap;

  // one-entry holding register when FIFOs are off
  assign cap = fifo_en ? CW'(DEPTH) : CW'(1);

  always_comb begin
    unique case (oversample_select)
      2'd1: ratio = 5'd8;
      2'd2: ratio = 5'd4;
      default: ratio = 5'd16;
    endcase
  end

  always_comb begin
    unique case (rx_trig_sel)
      2'd0: trig = CW'(`TRIG_0);
      2'd1: trig = CW'(`TRIG_1);
      2'd2: trig = CW'(`TRIG_2);
      2'd3: trig = CW'(`TRIG_3);
    endcase
  end

  always_ff @(posedge CLK_IN or negedge RST_B_IN) begin
    if (!RST_B_IN) begin
      irq_mask_reg <= `IRQ_MASK_RST;
      fifo_en <= 1'b0;
      rx_trig_sel <= `FCR_TRIG_RST;
      enh_en <= 1'b0;
      oversample_select <= `OVERSAMPLE_RST;
      RTS_OUT <= 1'b0;
    end else if (WR_IN) begin
      unique case (ADDR_IN)
        `REG_IRQ_MASK: begin
          irq_mask_reg[3:0] <= DATA_IN[3:0];
          if (enh_en) begin
            irq_mask_reg[7:4] <= DATA_IN[7:4];
          end
        end
        `REG_IDENT_FIFO: begin
          fifo_en <= DATA_IN[`FCR_ENABLE];
          rx_trig_sel <= DATA_IN[7:6];
        end
        `REG_ENH_FEATURE: enh_en <= DATA_IN[`EFR_ENHANCED];
        `REG_OVERSAMPLE: oversample_select <= DATA_IN[1:0];
        `REG_MODEM: RTS_OUT <= DATA_IN[`MCR_RTS];
        default: ;
      endcase
    end
  end

  always_ff @(posedge CLK_IN or negedge RST_B_IN) begin
    if (!RST_B_IN) begin
      div_cnt <= '0;
      tick <= 1'b0;
    end else if (div_cnt == DW'(SAMPLE_DIV - 1)) begin
      div_cnt <= '0;
      tick <= 1'b1;
    end else begin
      div_cnt <= div_cnt + DW'(1);
      tick <= 1'b0;
    end
  end

  always_ff @(posedge CLK_IN) begin
    if (tx_push) begin
      tx_mem[tx_wp] <= DATA_IN;
    end
    if (rx_push) begin
      rx_mem[rx_wp] <= rx_shift_reg;
    end
  end

  always_ff @(posedge CLK_IN or negedge RST_B_IN) begin
    if (!RST_B_IN) begin
      tx_wp <= '0;
      tx_rp <= '0;
      tx_count <= '0;
    end else if (tx_flush) begin
      tx_wp <= '0;
      tx_rp <= '0;
      tx_count <= '0;
    end else begin
      if (tx_push) begin
        tx_wp <= tx_wp == PW'(DEPTH - 1) ? '0 : tx_wp + PW'(1);
      end
      if (tx_pop) begin
        tx_rp <= tx_rp == PW'(DEPTH - 1) ? '0 : tx_rp + PW'(1);
      end
      tx_count <= tx_count + CW'(tx_push) - CW'(tx_pop);
    end
  end

  always_ff @(posedge CLK_IN or negedge RST_B_IN) begin
    if (!RST_B_IN) begin
      rx_wp <= '0;
      rx_rp <= '0;
      rx_count <= '0;
    end else if (rx_flush) begin
      rx_wp <= '0;
      rx_rp <= '0;
      rx_count <= '0;
    end else begin
      if (rx_push) begin
        rx_wp <= rx_wp == PW'(DEPTH - 1) ? '0 : rx_wp + PW'(1);
      end
      if (rx_pop) begin
        rx_rp <= rx_rp == PW'(DEPTH - 1) ? '0 : rx_rp + PW'(1);
      end
      rx_count <= rx_count + CW'(rx_push) - CW'(rx_pop);
    end
  end

  // transmitter: start, eight data bits lsb first, stop
  always_ff @(posedge CLK_IN or negedge RST_B_IN) begin
    if (!RST_B_IN) begin
      tx_state <= TX_IDLE;
      tx_shift_reg <= '1;
      tx_tick_cnt <= '0;
      tx_bit_cnt <= '0;
      TX_OUT <= 1'b1;
    end else begin
      unique case (tx_state)
        TX_IDLE: begin
          TX_OUT <= 1'b1;
          if (tx_pop) begin
            tx_shift_reg <= {1'b1, tx_mem[tx_rp], 1'b0};
            tx_tick_cnt <= '0;
            tx_bit_cnt <= '0;
            tx_state <= TX_SHIFT;
          end
        end
        TX_SHIFT: begin
          TX_OUT <= tx_shift_reg[0];
          if (tick) begin
            if (tx_tick_cnt == ratio - 5'd1) begin
              tx_tick_cnt <= '0;
              tx_shift_reg <= {1'b1, tx_shift_reg[9:1]};
              tx_bit_cnt <= tx_bit_cnt + 4'd1;
              if (tx_bit_cnt == 4'd9) begin
                tx_state <= TX_IDLE;
              end
            end else begin
              tx_tick_cnt <= tx_tick_cnt + 5'd1;
            end
          end
        end
      endcase
    end
  end

  // receiver with false-start rejection
  always_ff @(posedge CLK_IN or negedge RST_B_IN) begin
    if (!RST_B_IN) begin
      rx_state <= RX_IDLE;
      rx_prev <= 1'b1;
      rx_tick_cnt <= '0;
      rx_bit_cnt <= '0;
      rx_shift_reg <= '0;
    end else begin
      rx_prev <= RX_IN;
      unique case (rx_state)
        RX_IDLE: begin
          rx_tick_cnt <= '0;
          if (rx_prev && !RX_IN) begin
            rx_state <= RX_START;
          end
        end
        RX_START: begin
          if (tick) begin
            if (rx_tick_cnt == (ratio >> 1) - 5'd1) begin
              rx_tick_cnt <= '0;
              rx_bit_cnt <= '0;
              rx_state <= RX_IN ? RX_IDLE : RX_DATA;
            end else begin
              rx_tick_cnt <= rx_tick_cnt + 5'd1;
            end
          end
        end
        RX_DATA: begin
          if (tick) begin
            if (rx_tick_cnt == ratio - 5'd1) begin
              rx_tick_cnt <= '0;
              rx_shift_reg <= {RX_IN, rx_shift_reg[7:1]};
              rx_bit_cnt <= rx_bit_cnt + 4'd1;
              if (rx_bit_cnt == 4'd7) begin
                rx_state <= RX_STOP;
              end
            end else begin
              rx_tick_cnt <= rx_tick_cnt + 5'd1;
            end
          end
        end
        RX_STOP: begin
          if (tick) begin
            rx_tick_cnt <= rx_tick_cnt + 5'd1;
            if (frame_end) begin
              rx_tick_cnt <= '0;
              rx_state <= RX_IDLE;
            end
          end
        end
      endcase
    end
  end

  // error bits sticky until line status read; a new event wins
  always_ff @(posedge CLK_IN or negedge RST_B_IN) begin
    if (!RST_B_IN) begin
      line_err <= '0;
    end else begin
      if (rd_lsr) begin
        line_err <= '0;
      end
      if (frame_end && !RX_IN) begin
        line_err.framing <= 1'b1;
        if (rx_shift_reg == 8'h00) begin
          line_err.brk <= 1'b1;
        end
      end
      if (rx_overrun) begin
        line_err.overrun <= 1'b1;
      end
    end
  end

  always_ff @(posedge CLK_IN or negedge RST_B_IN) begin
    if (!RST_B_IN) begin
      modem_prev <= '0;
      modem_delta <= '0;
    end else begin
      modem_prev <= '{cd: CD_IN, ri: RI_IN, dsr: DSR_IN, cts: CTS_IN};
      modem_delta <= (rd_msr ? '0 : modem_delta)
        | modem_t'{cd: CD_IN != modem_prev.cd, ri: modem_prev.ri && !RI_IN,
            dsr: DSR_IN != modem_prev.dsr, cts: CTS_IN != modem_prev.cts};
    end
  end

  // event flags: clear on ident read, set wins
  always_ff @(posedge CLK_IN or negedge RST_B_IN) begin
    if (!RST_B_IN) begin
      cts_flag <= 1'b0;
      rts_flag <= 1'b0;
      xoff_flag <= 1'b0;
      tx_empty_flag <= 1'b0;
    end else begin
      cts_flag <= (cts_flag && !rd_isr) || (CTS_IN && !modem_prev.cts);
      rts_flag <= (rts_flag && !rd_isr)
        || (WR_IN && ADDR_IN == `REG_MODEM && DATA_IN[`MCR_RTS] && !RTS_OUT);
      xoff_flag <= (xoff_flag && !rd_isr) || (rx_push && rx_shift_reg == XOFF_CHAR);
      tx_empty_flag <= (tx_empty_flag && !rd_isr && !wr_data)
        || (tx_pop && tx_count == CW'(1) && !tx_push);
    end
  end

  always_comb begin
    ls_src = irq_mask_reg[`IER_LINE_STAT] && |line_err;
    rx_src = irq_mask_reg[`IER_RX_AVAIL]
      && (fifo_en ? rx_count >= trig : rx_count != '0);
    tx_src = irq_mask_reg[`IER_TX_ROOM]
      && (fifo_en ? tx_empty_flag : tx_count == '0);
    ms_src = irq_mask_reg[`IER_MODEM] && |modem_delta;
    xoff_src = irq_mask_reg[`IER_XOFF] && xoff_flag;
    rts_src = irq_mask_reg[`IER_RTS] && rts_flag;
    cts_src = irq_mask_reg[`IER_CTS] && cts_flag;
    if (ls_src) begin
      irq_ident_reg = `ISR_LINE;
    end else if (rx_src) begin
      irq_ident_reg = `ISR_RX;
    end else if (tx_src) begin
      irq_ident_reg = `ISR_TX;
    end else if (ms_src) begin
      irq_ident_reg = `ISR_MODEM;
    end else if (xoff_src) begin
      irq_ident_reg = `ISR_XOFF;
    end else if (rts_src || cts_src) begin
      irq_ident_reg = `ISR_FLOW;
    end else begin
      irq_ident_reg = `ISR_NONE;
    end
  end

  always_ff @(posedge CLK_IN or negedge RST_B_IN) begin
    if (!RST_B_IN) begin
      IRQ_OUT <= 1'b0;
      SLEEP_OUT <= 1'b0;
    end else begin
      IRQ_OUT <= ls_src || rx_src || tx_src || ms_src
        || xoff_src || rts_src || cts_src;
      SLEEP_OUT <= irq_mask_reg[`IER_SLEEP] && tx_state == TX_IDLE
        && tx_count == '0 && rx_state == RX_IDLE && !IRQ_OUT;
    end
  end

  always_ff @(posedge CLK_IN or negedge RST_B_IN) begin
    if (!RST_B_IN) begin
      DATA_OUT <= '0;
    end else if (RD_IN) begin
      unique case (ADDR_IN)
        `REG_DATA: DATA_OUT <= rx_count != '0 ? rx_mem[rx_rp] : 8'h00;
        `REG_IRQ_MASK: DATA_OUT <= irq_mask_reg;
        `REG_IDENT_FIFO: DATA_OUT <= irq_ident_reg;
        `REG_ENH_FEATURE: DATA_OUT <= {3'b000, enh_en, 4'h0};
        `REG_OVERSAMPLE: DATA_OUT <= {6'h00, oversample_select};
        `REG_LINE_STATUS: DATA_OUT <= {1'b0,
          tx_count == '0 && tx_state == TX_IDLE,
          tx_count == '0,
          line_err,
          rx_count != '0};
        `REG_MODEM: DATA_OUT <= {modem_prev, modem_delta};
        default: DATA_OUT <= 8'h00;
      endcase
    end
  end

endmodule

`default_nettype wire

// ===== uart_char_sva.sv
`include "uart_char_params.svh"
`timescale 1ns/1ps
`default_nettype none
module uart_char_sva import uart_char_pkg::*; #(parameter int SAMPLE_DIV = 1) (
  input wire logic CLK_IN,
  input wire logic RST_B_IN,
  input wire logic [2:0] ADDR_IN,
  input wire logic [7:0] DATA_IN,
  input wire logic WR_IN,
  input wire logic RD_IN,
  input wire logic CTS_IN,
  input wire logic DSR_IN,
  input wire logic [7:0] DATA_OUT,
  input wire logic IRQ_OUT,
  input wire logic TX_OUT,
  input wire logic RTS_OUT,
  input wire logic SLEEP_OUT
);
  localparam int QUIET = 192 * SAMPLE_DIV;
  logic [7:0] mask;
  logic enh;
  int quiet;
  // upper mask half follows writes only with the enhanced bit
  always_ff @(posedge CLK_IN or negedge RST_B_IN) begin
    if (!RST_B_IN) begin
      mask <= 8'h00;
      enh <= 1'b0;
    end else if (WR_IN && ADDR_IN == `REG_IRQ_MASK) begin
      mask <= enh ? DATA_IN : {mask[7:4], DATA_IN[3:0]};
    end else if (WR_IN && ADDR_IN == `REG_ENH_FEATURE) begin
      enh <= DATA_IN[`EFR_ENHANCED];
    end
  end
  // cycles of idle-high transmit line, saturating
  always_ff @(posedge CLK_IN or negedge RST_B_IN) begin
    if (!RST_B_IN) begin
      quiet <= 0;
    end else begin
      quiet <= !TX_OUT ? 0 : (quiet < 4096 ? quiet + 1 : quiet);
    end
  end
  default clocking cb @(posedge CLK_IN); endclocking
  default disable iff (!RST_B_IN);
  a_mask_readback: assert property (RD_IN && ADDR_IN == `REG_IRQ_MASK |=> DATA_OUT == mask)
    else $error("mask readback differs");
  a_unmapped_zero: assert property (RD_IN && ADDR_IN == 3'h7 |=> DATA_OUT == 8'h00)
    else $error("unmapped read not zero");
  a_data_holds: assert property (!RD_IN |=> $stable(DATA_OUT))
    else $error("read data moved without read");
  a_irq_masked: assert property ((mask == 8'h00) [*2] |-> !IRQ_OUT)
    else $error("interrupt with all sources masked");
  a_sleep_gated: assert property ((!mask[4]) [*2] |-> !SLEEP_OUT)
    else $error("sleep without enable");
  a_cts_irq: assert property (mask[7] && $rose(CTS_IN) |-> ##[1:4] IRQ_OUT)
    else $error("no interrupt on cts rise");
  a_rts_irq: assert property (mask[6] && $rose(RTS_OUT) |-> ##[0:3] IRQ_OUT)
    else $error("no interrupt on rts rise");
  a_modem_irq: assert property (mask[3] && $changed(DSR_IN) |-> ##[1:4] IRQ_OUT)
    else $error("no interrupt on modem change");
  a_tx_launch: assert property (WR_IN && ADDR_IN == `REG_DATA && quiet >= QUIET |-> ##3 !TX_OUT)
    else $error("start bit not launched");
  c_rx_irq: cover property (mask[0] && IRQ_OUT);
  c_tx_launch: cover property (WR_IN && ADDR_IN == `REG_DATA && quiet >= QUIET);
  c_sleep: cover property (SLEEP_OUT);
endmodule
bind uart_char_path uart_char_sva #(.SAMPLE_DIV(SAMPLE_DIV)) i_sva (.CLK_IN(CLK_IN),
  .RST_B_IN(RST_B_IN), .ADDR_IN(ADDR_IN), .DATA_IN(DATA_IN), .WR_IN(WR_IN), .RD_IN(RD_IN),
  .CTS_IN(CTS_IN), .DSR_IN(DSR_IN), .DATA_OUT(DATA_OUT), .IRQ_OUT(IRQ_OUT), .TX_OUT(TX_OUT),
  .RTS_OUT(RTS_OUT), .SLEEP_OUT(SLEEP_OUT));
`default_nettype wire

// ===== serial_line.sv
`timescale 1ns/1ps
`default_nettype none
module serial_line #(parameter int BT = 16) (
  input wire logic clk_in,
  input wire logic tx_in,
  output logic rx_out
);
  logic [7:0] got [0:7];
  int n_got = 0;
  initial rx_out = 1'b1;
  // 8N1 frame, lsb first; the task drives the line back high after each frame
  task automatic send(input logic [7:0] d, input logic stop, input int bt);
    logic [9:0] f;
    f = {stop, d, 1'b0};
    for (int i = 0; i < 10; i++) begin
      @(posedge clk_in) rx_out <= f[i];
      repeat (bt - 1) @(posedge clk_in);
    end
    @(posedge clk_in) rx_out <= 1'b1;
  endtask
  task automatic glitch(input int n);
    @(posedge clk_in) rx_out <= 1'b0;
    repeat (n) @(posedge clk_in);
    rx_out <= 1'b1;
  endtask
  always begin
    @(negedge tx_in);
    repeat (BT / 2) @(posedge clk_in);
    for (int i = 0; i < 8; i++) begin
      repeat (BT) @(posedge clk_in);
      got[n_got % 8][i] = tx_in;
    end
    n_got++;
  end
endmodule
`default_nettype wire

// ===== uart_holding_regs_irq_enable_tb.sv
`include "uart_char_params.svh"
`timescale 1ns/1ps
`default_nettype none
module uart_holding_regs_irq_enable_tb import uart_char_pkg::*;;
  logic clk = 1'b0;
  logic rst_b = 1'b0;
  logic wr = 1'b0, rd = 1'b0, cts = 1'b0, dsr = 1'b0, ri = 1'b0, cd = 1'b0;
  logic [2:0] addr = 3'h0;
  logic [7:0] din = 8'h00;
  logic [7:0] dout, rv;
  logic irq, tx, rts, sleep, rx;
  int n_mismatch = 0;
  int tests_run = 0;
  int ratio [4] = '{16, 8, 4, 16};
  always #4 clk = ~clk;
  uart_char_path #(.XOFF_CHAR(8'h13)) i_dut (.CLK_IN(clk), .RST_B_IN(rst_b), .ADDR_IN(addr),
    .DATA_IN(din), .WR_IN(wr), .RD_IN(rd), .RX_IN(rx), .CTS_IN(cts), .DSR_IN(dsr),
    .RI_IN(ri), .CD_IN(cd), .DATA_OUT(dout), .IRQ_OUT(irq), .TX_OUT(tx),
    .RTS_OUT(rts), .SLEEP_OUT(sleep));
  serial_line i_line (.clk_in(clk), .tx_in(tx), .rx_out(rx));
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    tests_run++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("wrong value at %0t ns: got %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wt(input int n);
    repeat (n) @(posedge clk);
  endtask
  task automatic wreg(input logic [2:0] a, input logic [7:0] d);
    @(posedge clk);
    addr <= a;
    din <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  task automatic rchk(input logic [2:0] a, input logic [7:0] exp);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    @(negedge clk);
    chk(dout, exp);
  endtask
  // pins are read after the wait, not when the task is called
  task automatic irq_is(input logic e);
    wt(3);
    @(negedge clk);
    chk({7'h00, irq}, {7'h00, e});
  endtask
  task automatic sleep_is(input logic e);
    wt(3);
    @(negedge clk);
    chk({7'h00, sleep}, {7'h00, e});
  endtask
  task automatic final_report();
    if (n_mismatch == 0 && tests_run > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  initial begin
    wt(30000);
    n_mismatch++;
    final_report();
  end
  initial begin
    wt(2);
    rst_b <= 1'b1;
    rchk(`REG_IRQ_MASK, `IRQ_MASK_RST);
    wreg(`REG_IRQ_MASK, 8'hff);
    rchk(`REG_IRQ_MASK, 8'h0f);
    irq_is(1'b1);
    rchk(`REG_IDENT_FIFO, `ISR_TX);
    wreg(`REG_IRQ_MASK, 8'h00);
    irq_is(1'b0);
    wreg(`REG_ENH_FEATURE, 8'h10);
    wreg(`REG_IRQ_MASK, 8'h10);
    sleep_is(1'b1);
    wreg(`REG_IRQ_MASK, 8'hc0);
    sleep_is(1'b0);
    @(posedge clk) cts <= 1'b1;
    irq_is(1'b1);
    rchk(`REG_IDENT_FIFO, `ISR_FLOW);
    irq_is(1'b0);
    wreg(`REG_MODEM, 8'h02);
    irq_is(1'b1);
    chk({7'h00, rts}, 8'h01);
    rchk(`REG_IDENT_FIFO, `ISR_FLOW);
    rchk(`REG_MODEM, 8'h11);
    wreg(`REG_IRQ_MASK, 8'h08);
    irq_is(1'b0);
    @(posedge clk) dsr <= 1'b1;
    irq_is(1'b1);
    rchk(`REG_IDENT_FIFO, `ISR_MODEM);
    rchk(`REG_MODEM, 8'h32);
    irq_is(1'b0);
    @(posedge clk) cd <= 1'b1;
    irq_is(1'b1);
    wreg(`REG_IRQ_MASK, 8'h20);
    irq_is(1'b0);
    i_line.send(8'h13, 1'b1, 16);
    irq_is(1'b1);
    rchk(`REG_IDENT_FIFO, `ISR_XOFF);
    rchk(`REG_DATA, 8'h13);
    wreg(`REG_IRQ_MASK, 8'h01);
    for (int s = 0; s < 4; s++) begin
      wreg(`REG_OVERSAMPLE, 8'(s));
      i_line.glitch(ratio[s] / 4);
      wt(3 * ratio[s]);
      rchk(`REG_LINE_STATUS, 8'h60);
      i_line.send(8'(8'h96 + s), 1'b1, ratio[s]);
      irq_is(1'b1);
      rchk(`REG_LINE_STATUS, 8'h61);
      rchk(`REG_DATA, 8'(8'h96 + s));
      irq_is(1'b0);
    end
    wreg(`REG_IRQ_MASK, 8'h04);
    i_line.send(8'h00, 1'b0, 16);
    irq_is(1'b1);
    rchk(`REG_IDENT_FIFO, `ISR_LINE);
    rchk(`REG_LINE_STATUS, 8'h78);
    irq_is(1'b0);
    wreg(`REG_IDENT_FIFO, 8'h01);
    wreg(`REG_IRQ_MASK, 8'h02);
    irq_is(1'b0);
    wreg(`REG_DATA, 8'hc3);
    wreg(`REG_DATA, 8'h3c);
    rchk(`REG_LINE_STATUS, 8'h00);
    for (int i = 0; i < 800 && i_line.n_got < 2; i++) wt(1);
    wt(24);
    chk(i_line.got[0], 8'hc3);
    chk(i_line.got[1], 8'h3c);
    irq_is(1'b1);
    rchk(`REG_LINE_STATUS, 8'h60);
    rchk(`REG_IDENT_FIFO, `ISR_TX);
    irq_is(1'b0);
    wreg(`REG_IRQ_MASK, 8'h01);
    for (int i = 0; i < 8; i++) begin
      i_line.send(8'(i), 1'b1, 16);
      if (i == 6) irq_is(1'b0);
    end
    irq_is(1'b1);
    rchk(`REG_IDENT_FIFO, `ISR_RX);
    rchk(`REG_DATA, 8'h00);
    irq_is(1'b0);
    rchk(`REG_IDENT_FIFO, `ISR_NONE);
    for (int i = 1; i < 8; i++) rchk(`REG_DATA, 8'(i));
    rchk(`REG_LINE_STATUS, 8'h60);
    rchk(`REG_DATA, 8'h00);
    rchk(3'h7, 8'h00);
    i_line.send(8'h55, 1'b1, 16);
    rchk(`REG_LINE_STATUS, 8'h61);
    wreg(`REG_IDENT_FIFO, 8'h03);
    rchk(`REG_LINE_STATUS, 8'h60);
    final_report();
  end
endmodule
`default_nettype wire
